// [core/tsd_pkg.sv]
// What this block does
// - Security bit 0 blocks test-port tile access
// - Security bit 1 denies switch access requests
// - Security bit 5 forces boot from OTP
// - Security bit 7 enables redundant OTP rows
// - Bits 8-11 lock OTP sector programming
// - Bit 12 blocks all OTP programming
// - Bit 13 denies test-port OTP access
// - Bit 14 disables debug-sync pin entirely
// - Bits 21:15 hold readable general field
// - Bits 31:22 hold user code extension
// - Security word loads before taking effect
// - Chain holds boundary and chip controllers
// - Boundary controller follows standard tap behaviour
// - Chip controller reaches tile and OTP
// - Test reset low keeps test logic reset
// - Sync pin floats until breakpoint, drives low
// - Low sync pin input enters debug mode
// - Identity instruction shifts version, part, maker, one
// - User code: owner tag, unused, revision
// - Owner tag copies tile 0 bits 31:22
package tsd_pkg;
	// Security word bit positions
	localparam int SEC_NO_TEST = 0;
	localparam int SEC_NO_SWITCH = 1;
	localparam int SEC_OTP_BOOT = 5;
	localparam int SEC_REDUNDANT = 7;
	localparam int SEC_LOCK_LO = 8;
	localparam int SEC_MASTER_LOCK = 12;
	localparam int SEC_NO_TEST_OTP = 13;
	localparam int SEC_NO_DEBUG_PIN = 14;
	localparam int SEC_GP_LO = 15;
	localparam int SEC_GP_HI = 21;
	localparam int SEC_EXT_LO = 22;
	localparam int SEC_EXT_HI = 31;
	// Value held before the OTP load completes: most locked
	localparam logic [31:0] SEC_RESET = 32'h00007F03;
	// Identity fields, values arbitrary
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART = 16'h00A5;
	localparam logic [10:0] ID_MAKER = 11'h05A;
	localparam logic [9:0] REVISION = 10'h001;
	// Instruction register width and codes
	localparam int IR_W = 4;
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_SAMPLE = 4'h1;
	localparam logic [3:0] IR_TEST_DEVICE_IDENTITY = 4'h2;
	localparam logic [3:0] IR_USERCODE = 4'h3;
	localparam logic [3:0] IR_CHIP_DATA = 4'h8;
	localparam logic [3:0] IR_OTP_DATA = 4'h9;
	localparam logic [3:0] IR_BYPASS = 4'hF;
	// Test reset least hold time, in ns and in sys cycles
	localparam int TRST_MIN_NS = 100;
	localparam int SYS_PERIOD_NS = 5;
	localparam int TRST_MIN_CYC = (TRST_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// Tap controller states
	typedef enum logic [3:0] {
		TSD_RESET, TSD_IDLE, TSD_SEL_DR, TSD_CAP_DR, TSD_SH_DR, TSD_EX1_DR,
		TSD_PAU_DR, TSD_EX2_DR, TSD_UPD_DR, TSD_SEL_IR, TSD_CAP_IR, TSD_SH_IR,
		TSD_EX1_IR, TSD_PAU_IR, TSD_EX2_IR, TSD_UPD_IR
	} tsd_tap_e;
endpackage

// [core/tsd_tap.sv]
`timescale 1ns/1ps
`default_nettype none
// One standard tap controller with IR, identity, user code, bypass and a data path
module tsd_tap #(
	parameter int DR_W = 32
) (
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	input wire logic [31:0] test_device_identity,
	input wire logic [31:0] usercode,
	input wire logic [DR_W-1:0] cap_data,
	output logic [tsd_pkg::IR_W-1:0] ir,
	output logic [DR_W-1:0] upd_data,
	output logic upd_pulse
);
	// The shared shift stage holds at most one 32-bit word
	if (DR_W < 1 || DR_W > 32)
	begin : g_bad_dr_w
		$error("DR_W must lie between 1 and 32");
	end
	tsd_pkg::tsd_tap_e st_reg; // Controller state
	tsd_pkg::tsd_tap_e st_next;
	logic [tsd_pkg::IR_W-1:0] ir_sh_reg; // IR shift stage
	logic [31:0] dr_sh_reg; // Shared data shift stage
	logic byp_reg; // Bypass bit

	// Standard next-state map
	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			tsd_pkg::TSD_RESET: st_next = tms ? tsd_pkg::TSD_RESET : tsd_pkg::TSD_IDLE;
			tsd_pkg::TSD_IDLE: st_next = tms ? tsd_pkg::TSD_SEL_DR : tsd_pkg::TSD_IDLE;
			tsd_pkg::TSD_SEL_DR: st_next = tms ? tsd_pkg::TSD_SEL_IR : tsd_pkg::TSD_CAP_DR;
			tsd_pkg::TSD_CAP_DR: st_next = tms ? tsd_pkg::TSD_EX1_DR : tsd_pkg::TSD_SH_DR;
			tsd_pkg::TSD_SH_DR: st_next = tms ? tsd_pkg::TSD_EX1_DR : tsd_pkg::TSD_SH_DR;
			tsd_pkg::TSD_EX1_DR: st_next = tms ? tsd_pkg::TSD_UPD_DR : tsd_pkg::TSD_PAU_DR;
			tsd_pkg::TSD_PAU_DR: st_next = tms ? tsd_pkg::TSD_EX2_DR : tsd_pkg::TSD_PAU_DR;
			tsd_pkg::TSD_EX2_DR: st_next = tms ? tsd_pkg::TSD_UPD_DR : tsd_pkg::TSD_SH_DR;
			tsd_pkg::TSD_UPD_DR: st_next = tms ? tsd_pkg::TSD_SEL_DR : tsd_pkg::TSD_IDLE;
			tsd_pkg::TSD_SEL_IR: st_next = tms ? tsd_pkg::TSD_RESET : tsd_pkg::TSD_CAP_IR;
			tsd_pkg::TSD_CAP_IR: st_next = tms ? tsd_pkg::TSD_EX1_IR : tsd_pkg::TSD_SH_IR;
			tsd_pkg::TSD_SH_IR: st_next = tms ? tsd_pkg::TSD_EX1_IR : tsd_pkg::TSD_SH_IR;
			tsd_pkg::TSD_EX1_IR: st_next = tms ? tsd_pkg::TSD_UPD_IR : tsd_pkg::TSD_PAU_IR;
			tsd_pkg::TSD_PAU_IR: st_next = tms ? tsd_pkg::TSD_EX2_IR : tsd_pkg::TSD_PAU_IR;
			tsd_pkg::TSD_EX2_IR: st_next = tms ? tsd_pkg::TSD_UPD_IR : tsd_pkg::TSD_SH_IR;
			tsd_pkg::TSD_UPD_IR: st_next = tms ? tsd_pkg::TSD_SEL_DR : tsd_pkg::TSD_IDLE;
			default: st_next = tsd_pkg::TSD_RESET;
		endcase
	end

	// State register; test reset holds it in reset
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			st_reg <= tsd_pkg::TSD_RESET;
		else
			st_reg <= st_next;
	end

	// Instruction shift and update; reset selects identity
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			ir_sh_reg <= '0;
			ir <= tsd_pkg::IR_TEST_DEVICE_IDENTITY;
		end
		else if (st_reg == tsd_pkg::TSD_RESET)
			ir <= tsd_pkg::IR_TEST_DEVICE_IDENTITY;
		else if (st_reg == tsd_pkg::TSD_CAP_IR)
			ir_sh_reg <= 4'h1; // Capture pattern ends in 01
		else if (st_reg == tsd_pkg::TSD_SH_IR)
			ir_sh_reg <= {tdi, ir_sh_reg[tsd_pkg::IR_W-1:1]};
		else if (st_reg == tsd_pkg::TSD_UPD_IR)
			ir <= ir_sh_reg;
	end

	// Data capture and shift by selected instruction
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			dr_sh_reg <= '0;
			byp_reg <= 1'b0;
		end
		else if (st_reg == tsd_pkg::TSD_CAP_DR)
		begin
			byp_reg <= 1'b0;
			case (ir)
				tsd_pkg::IR_TEST_DEVICE_IDENTITY: dr_sh_reg <= test_device_identity;
				tsd_pkg::IR_USERCODE: dr_sh_reg <= usercode;
				default: dr_sh_reg <= 32'(cap_data);
			endcase
		end
		else if (st_reg == tsd_pkg::TSD_SH_DR)
		begin
			byp_reg <= tdi;
			if (ir == tsd_pkg::IR_TEST_DEVICE_IDENTITY || ir == tsd_pkg::IR_USERCODE)
				dr_sh_reg <= {tdi, dr_sh_reg[31:1]};
			else
				// Works down to a one-bit path, where no upper slice exists
				dr_sh_reg <= 32'((dr_sh_reg[DR_W-1:0] >> 1) | (DR_W'(tdi) << (DR_W - 1)));
		end
	end

	// Update strobe with shifted data
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			upd_data <= '0;
			upd_pulse <= 1'b0;
		end
		else
		begin
			upd_pulse <= (st_reg == tsd_pkg::TSD_UPD_DR);
			if (st_reg == tsd_pkg::TSD_UPD_DR)
				upd_data <= dr_sh_reg[DR_W-1:0];
		end
	end

	// Output changes on falling edge as the standard asks
	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
			tdo <= 1'b0;
		else if (st_reg == tsd_pkg::TSD_SH_IR)
			tdo <= ir_sh_reg[0];
		else if (st_reg == tsd_pkg::TSD_SH_DR)
			tdo <= (ir == tsd_pkg::IR_BYPASS) ? byp_reg : dr_sh_reg[0];
	end
endmodule // tsd_tap
`default_nettype wire

// [core/tsd_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Tile security word, two chained test controllers and debug sync pin
module tsd_top #(
	parameter int SECTORS = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	// Security word load from OTP
	input wire logic otp_load_valid,
	input wire logic [31:0] otp_load_word,
	input wire logic [31:0] tile0_security_word,
	output logic [31:0] tile_security_config,
	output logic sec_loaded,
	// Security policy outputs
	output logic boot_from_otp,
	output logic otp_redundant_rows,
	// OTP programming request from tile side
	input wire logic otp_prog_req,
	input wire logic [1:0] otp_prog_sector,
	input wire logic otp_prog_sec_word,
	output logic otp_prog_grant,
	output logic otp_prog_deny,
	// Switch access from other tiles
	input wire logic switch_req,
	output logic switch_grant,
	output logic switch_deny,
	// Debug state
	input wire logic breakpoint_hit,
	input wire logic debug_out_en,
	input wire logic debug_in_en,
	output logic debug_enter,
	input wire logic debug_sync_in,
	output logic debug_sync_out,
	output logic debug_sync_oe_n,
	// Test link, own clock
	input wire logic test_clk,
	input wire logic test_rst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	// Test-port actions toward tile and OTP
	output logic test_tile_wr,
	output logic test_otp_wr,
	output logic [31:0] test_wr_data
);
	if (SECTORS != 4)
	begin : g_bad_sectors
		$error("SECTORS must be 4");
	end
	logic [31:0] sec_reg; // Loaded security word
	logic loaded_reg; // Load done
	logic [31:0] test_device_identity_w; // Identity word
	logic [31:0] user_w; // User code word
	logic chain_mid; // Boundary tdo into chip tdi
	logic tdo_chip; // Chip tdo
	logic [3:0] ir_chip; // Chip controller instruction
	logic [31:0] chip_upd;
	logic chip_pulse;
	logic [31:0] chip_cap;
	// Security bits crossed into test domain
	logic [2:0] no_test_s, no_otp_s, ld_s;
	logic allow_test_t, allow_otp_t;
	// Write event toggle crossing back
	logic wr_tog_t;
	logic wr_tile_t, wr_otp_t;
	logic [31:0] wr_data_t;
	logic [2:0] tog_s;
	logic [1:0] tog_fill_reg; // Sys cycles since reset, stops at 3
	logic tog_edge; // Toggle change, ignored until the stages hold fresh samples
	// Debug pin sampling
	logic [2:0] dbg_s;
	logic dbg_low;

	// Load security word once; defaults hold everything locked
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sec_reg <= tsd_pkg::SEC_RESET;
			loaded_reg <= 1'b0;
		end
		else if (otp_load_valid && !loaded_reg)
		begin
			sec_reg <= otp_load_word;
			loaded_reg <= 1'b1;
		end
	end

	// Policy outputs, registered; all but the config word quiet until loaded
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tile_security_config <= '0;
			sec_loaded <= 1'b0;
			boot_from_otp <= 1'b0;
			otp_redundant_rows <= 1'b0;
		end
		else
		begin
			// Whole word visible: gp field 21:15 and extension 31:22
			tile_security_config <= sec_reg;
			sec_loaded <= loaded_reg;
			boot_from_otp <= loaded_reg && sec_reg[tsd_pkg::SEC_OTP_BOOT];
			otp_redundant_rows <= loaded_reg && sec_reg[tsd_pkg::SEC_REDUNDANT];
		end
	end

	// OTP programming gate: master lock, then sector locks
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			otp_prog_grant <= 1'b0;
			otp_prog_deny <= 1'b0;
		end
		else if (otp_prog_req)
		begin
			if (!loaded_reg || sec_reg[tsd_pkg::SEC_MASTER_LOCK])
			begin
				otp_prog_grant <= 1'b0;
				otp_prog_deny <= 1'b1;
			end
			else if (!otp_prog_sec_word && sec_reg[tsd_pkg::SEC_LOCK_LO + otp_prog_sector])
			begin
				otp_prog_grant <= 1'b0;
				otp_prog_deny <= 1'b1;
			end
			else
			begin
				otp_prog_grant <= 1'b1;
				otp_prog_deny <= 1'b0;
			end
		end
		else
		begin
			otp_prog_grant <= 1'b0;
			otp_prog_deny <= 1'b0;
		end
	end

	// Switch access gate
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			switch_grant <= 1'b0;
			switch_deny <= 1'b0;
		end
		else
		begin
			switch_grant <= switch_req && loaded_reg && !sec_reg[tsd_pkg::SEC_NO_SWITCH];
			switch_deny <= switch_req && !(loaded_reg && !sec_reg[tsd_pkg::SEC_NO_SWITCH]);
		end
	end

	// Debug pin input: three stages, change when last two agree
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dbg_s <= 3'h7;
			dbg_low <= 1'b0;
		end
		else
		begin
			dbg_s <= {dbg_s[1:0], debug_sync_in};
			if (dbg_s[2] == dbg_s[1])
				dbg_low <= !dbg_s[2];
		end
	end

	// Debug pin behaviour; bit 14 silences both directions
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			debug_sync_out <= 1'b0;
			debug_sync_oe_n <= 1'b1;
			debug_enter <= 1'b0;
		end
		else if (!loaded_reg || sec_reg[tsd_pkg::SEC_NO_DEBUG_PIN])
		begin
			debug_sync_out <= 1'b0;
			debug_sync_oe_n <= 1'b1;
			debug_enter <= 1'b0;
		end
		else
		begin
			debug_sync_out <= 1'b0;
			// Float until breakpoint, then pull low
			debug_sync_oe_n <= !(debug_out_en && breakpoint_hit);
			debug_enter <= debug_in_en && dbg_low;
		end
	end

	// Identity and user code words
	always_comb
	begin
		test_device_identity_w = {tsd_pkg::ID_VERSION, tsd_pkg::ID_PART, tsd_pkg::ID_MAKER, 1'b1};
		user_w = {tile0_security_word[tsd_pkg::SEC_EXT_HI:tsd_pkg::SEC_EXT_LO],
			12'h000, tsd_pkg::REVISION};
	end

	// Security bits into test domain: three stages, agree on last two
	always_ff @(posedge test_clk or negedge test_rst_n)
	begin
		if (!test_rst_n)
		begin
			no_test_s <= 3'h7;
			no_otp_s <= 3'h7;
			ld_s <= 3'h0;
			allow_test_t <= 1'b0;
			allow_otp_t <= 1'b0;
		end
		else
		begin
			no_test_s <= {no_test_s[1:0], sec_reg[tsd_pkg::SEC_NO_TEST]};
			no_otp_s <= {no_otp_s[1:0], sec_reg[tsd_pkg::SEC_NO_TEST_OTP]};
			ld_s <= {ld_s[1:0], loaded_reg};
			if (no_test_s[2] == no_test_s[1] && ld_s[2] == ld_s[1])
				allow_test_t <= ld_s[2] && !no_test_s[2];
			if (no_otp_s[2] == no_otp_s[1] && no_test_s[2] == no_test_s[1]
				&& ld_s[2] == ld_s[1])
				allow_otp_t <= ld_s[2] && !no_otp_s[2] && !no_test_s[2];
		end
	end

	// Boundary controller first in chain
	tsd_tap #(.DR_W(1)) u_bscan (
		.tck(test_clk),
		.trst_n(test_rst_n),
		.tms(tms),
		.tdi(tdi),
		.tdo(chain_mid),
		.test_device_identity(test_device_identity_w),
		.usercode(user_w),
		.cap_data(1'b0),
		.ir(),
		.upd_data(),
		.upd_pulse()
	);

	// Chip controller; captures only what security allows
	always_comb
	begin
		chip_cap = 32'h00000000;
		if (ir_chip == tsd_pkg::IR_CHIP_DATA && allow_test_t)
			chip_cap = sec_reg;
		else if (ir_chip == tsd_pkg::IR_OTP_DATA && allow_otp_t)
			chip_cap = sec_reg;
	end

	tsd_tap #(.DR_W(32)) u_chip (
		.tck(test_clk),
		.trst_n(test_rst_n),
		.tms(tms),
		.tdi(chain_mid),
		.tdo(tdo_chip),
		.test_device_identity(test_device_identity_w),
		.usercode(user_w),
		.cap_data(chip_cap),
		.ir(ir_chip),
		.upd_data(chip_upd),
		.upd_pulse(chip_pulse)
	);

	// Chain output register
	always_ff @(posedge test_clk or negedge test_rst_n)
	begin
		if (!test_rst_n)
			tdo <= 1'b0;
		else
			tdo <= tdo_chip;
	end

	// Latch permitted writes, announce by toggle
	always_ff @(posedge test_clk or negedge test_rst_n)
	begin
		if (!test_rst_n)
		begin
			wr_tog_t <= 1'b0;
			wr_tile_t <= 1'b0;
			wr_otp_t <= 1'b0;
			wr_data_t <= '0;
		end
		else if (chip_pulse && ((ir_chip == tsd_pkg::IR_CHIP_DATA && allow_test_t)
			|| (ir_chip == tsd_pkg::IR_OTP_DATA && allow_otp_t)))
		begin
			wr_tog_t <= !wr_tog_t;
			wr_tile_t <= (ir_chip == tsd_pkg::IR_CHIP_DATA);
			wr_otp_t <= (ir_chip == tsd_pkg::IR_OTP_DATA);
			wr_data_t <= chip_upd;
		end
	end

	// Write landing in the first cycles after reset is lost: price of no false pulse
	assign tog_edge = (tog_s[2] != tog_s[1]) && (tog_fill_reg == 2'h3);

	// Toggle into system domain; data stable while toggle settles
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tog_s <= 3'h0;
			tog_fill_reg <= 2'h0;
			test_tile_wr <= 1'b0;
			test_otp_wr <= 1'b0;
			test_wr_data <= '0;
		end
		else
		begin
			tog_s <= {tog_s[1:0], wr_tog_t};
			// Stage values from before reset would look like a fresh toggle
			if (tog_fill_reg != 2'h3)
				tog_fill_reg <= tog_fill_reg + 2'h1;
			test_tile_wr <= tog_edge && wr_tile_t;
			test_otp_wr <= tog_edge && wr_otp_t
				&& !sec_reg[tsd_pkg::SEC_MASTER_LOCK];
			if (tog_edge)
				test_wr_data <= wr_data_t;
		end
	end

	// Assertions
	a_switch_deny_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		switch_req && sec_reg[1] |=> !switch_grant && switch_deny)
		else $error("switch granted while locked");
	a_boot_otp_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		boot_from_otp |-> $past(sec_reg[5]) && $past(loaded_reg))
		else $error("otp boot without bit");
	a_redundant_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		otp_redundant_rows == $past(loaded_reg && sec_reg[7]))
		else $error("redundant rows mismatch");
	a_sector_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		otp_prog_req && !otp_prog_sec_word && sec_reg[8 + otp_prog_sector]
		|=> otp_prog_deny)
		else $error("locked sector programmed");
	a_master_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		otp_prog_req && sec_reg[12] |=> !otp_prog_grant)
		else $error("master lock ignored");
	a_debug_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sec_reg[14] |=> debug_sync_oe_n && !debug_enter)
		else $error("debug pin active while disabled");
	a_debug_drive_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!debug_sync_oe_n |-> !debug_sync_out && $past(breakpoint_hit))
		else $error("debug pin driven wrongly");
	a_load_before_use: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!loaded_reg |=> !boot_from_otp && !otp_prog_grant && !switch_grant)
		else $error("policy before load");
	a_word_readout: assert property (@(posedge sys_clk) disable iff (!rst_n)
		loaded_reg && $stable(sec_reg) |=> tile_security_config[31:15] == sec_reg[31:15])
		else $error("security word readout wrong");
	a_test_otp_block: assert property (@(posedge test_clk) disable iff (!test_rst_n)
		chip_pulse && !allow_otp_t && ir_chip == 4'h9 |=> $stable(wr_tog_t))
		else $error("otp write through test port");
	a_test_tile_block: assert property (@(posedge test_clk) disable iff (!test_rst_n)
		chip_pulse && !allow_test_t && ir_chip == 4'h8 |=> $stable(wr_tog_t))
		else $error("tile write through test port");
	c_prog_granted: cover property (@(posedge sys_clk) disable iff (!rst_n) otp_prog_grant);
	c_debug_enter: cover property (@(posedge sys_clk) disable iff (!rst_n) debug_enter);
	c_test_write: cover property (@(posedge sys_clk) disable iff (!rst_n) test_tile_wr);
	c_switch_ok: cover property (@(posedge sys_clk) disable iff (!rst_n) switch_grant);
endmodule // tsd_top
`default_nettype wire

// [test/tsd_jtag_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Test host: its clock runs only inside scans and the idle walk, and stands low between them
module tsd_jtag_host (
	output logic test_clk,
	output logic test_rst_n,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	logic [63:0] rec; // Sampled tdo stream of the last scan
	int idx;
	initial
	begin
		test_clk = 1'b0;
		test_rst_n = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		rec = 64'h0;
		idx = 0;
	end
	// One 64 ns cycle; lines move only while the clock is low
	task automatic tick(input logic m, input logic d);
		tms = m;
		tdi = d;
		#32;
		rec[idx] = tdo;
		idx++;
		test_clk = 1'b1;
		#32;
		test_clk = 1'b0;
	endtask
	// Reset held low from power-up, released no earlier than asked
	task automatic release_reset(input int ns);
		#(ns);
		test_rst_n = 1'b1;
	endtask
	// Five high tms cycles reach reset from any state
	task automatic to_idle();
		repeat (5) tick(1'b1, ~tdi);
		tick(1'b0, ~tdi);
	endtask
	// Idle to shift, n bits LSB first, update, back to idle; tdi toggles when unused
	task automatic scan(input logic ir, input int n, input logic [63:0] din);
		idx = 0;
		tick(1'b1, ~tdi);
		if (ir)
			tick(1'b1, ~tdi);
		tick(1'b0, ~tdi);
		tick(1'b0, ~tdi);
		for (int i = 0; i < n; i++)
			tick(i == n - 1, din[i]);
		tick(1'b1, ~tdi);
		repeat (4) tick(1'b0, ~tdi);
	endtask
endmodule // tsd_jtag_host
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [31:0] W1 = 32'hB36D85A2; // Link off, OTP boot, locks 0 and 2
	localparam logic [31:0] W2 = 32'h4C927000; // Master lock, no test OTP, no pin
	localparam logic [31:0] W3 = 32'h00000001; // Test port shut out of tile
	localparam logic [31:0] D1 = 32'h5AC3961E;
	localparam logic [31:0] D2 = 32'hC0FFEE11;
	logic sys_clk = 1'b0;
	logic rst_n, otp_load_valid, sec_loaded, boot_from_otp, otp_redundant_rows;
	logic [31:0] otp_load_word, tile0_security_word, tile_security_config, test_wr_data;
	logic otp_prog_req, otp_prog_sec_word, otp_prog_grant, otp_prog_deny;
	logic [1:0] otp_prog_sector;
	logic switch_req, switch_grant, switch_deny, breakpoint_hit, debug_out_en;
	logic debug_in_en, debug_enter, debug_sync_in, debug_sync_out, debug_sync_oe_n;
	logic test_clk, test_rst_n, tms, tdi, tdo, test_tile_wr, test_otp_wr, ext_low;
	logic [31:0] errors = 32'h0;
	logic [31:0] samples_checked = 32'h0;
	logic [31:0] tile_wrs = 32'h0;
	logic [31:0] otp_wrs = 32'h0;
	logic [31:0] wr_seen = 32'h0;
	int cycles = 0;
	// Pin has a pull-up: low only when the device or the far side pulls it
	assign debug_sync_in = ~((~debug_sync_oe_n & ~debug_sync_out) | ext_low);
	always #2.5 sys_clk = ~sys_clk;
	tsd_top tsd_top_i (.sys_clk, .rst_n, .otp_load_valid, .otp_load_word,
		.tile0_security_word, .tile_security_config, .sec_loaded, .boot_from_otp,
		.otp_redundant_rows, .otp_prog_req, .otp_prog_sector, .otp_prog_sec_word,
		.otp_prog_grant, .otp_prog_deny, .switch_req, .switch_grant, .switch_deny,
		.breakpoint_hit, .debug_out_en, .debug_in_en, .debug_enter, .debug_sync_in,
		.debug_sync_out, .debug_sync_oe_n, .test_clk, .test_rst_n, .tms, .tdi, .tdo,
		.test_tile_wr, .test_otp_wr, .test_wr_data);
	tsd_jtag_host tsd_jtag_host_i (.test_clk, .test_rst_n, .tms, .tdi, .tdo);
	// Counts write pulses mid-cycle, where they stand settled; data kept from the last one
	always @(negedge sys_clk)
	begin
		cycles++;
		if (test_tile_wr === 1'b1)
			tile_wrs <= tile_wrs + 32'h1;
		if (test_otp_wr === 1'b1)
			otp_wrs <= otp_wrs + 32'h1;
		if ((test_tile_wr | test_otp_wr) === 1'b1)
			wr_seen <= test_wr_data;
		if (cycles == 40000)
		begin
			errors = errors + 32'h1;
			final_report();
		end
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked = samples_checked + 32'h1;
		if (got !== exp)
		begin
			errors = errors + 32'h1;
			$display("[ERR] %0t word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked = samples_checked + 32'h1;
		if (got !== exp)
		begin
			errors = errors + 32'h1;
			$display("[ERR] %0t bit %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 32'h0 && samples_checked != 32'h0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// The tdo pipeline depth is loose, so the word is looked for at offsets 0 to 23
	function automatic logic found(input logic [63:0] s, input logic [31:0] v);
		found = 1'b0;
		for (int k = 0; k < 24; k++)
			if (s[k +: 32] === v)
				found = 1'b1;
	endfunction
	// Request held high across back-to-back calls; answer one cycle later
	task automatic prog(input logic [1:0] s, input logic sw, input logic ok);
		otp_prog_sector = s;
		otp_prog_sec_word = sw;
		otp_prog_req = 1'b1;
		@(negedge sys_clk);
		chk_bit(otp_prog_grant, ok);
		chk_bit(otp_prog_deny, ~ok);
	endtask
	task automatic sw_req(input logic ok);
		switch_req = 1'b1;
		@(negedge sys_clk);
		chk_bit(switch_grant, ok);
		chk_bit(switch_deny, ~ok);
		switch_req = 1'b0;
	endtask
	// Reset, probe the locked default, then load a word
	task automatic boot(input logic [31:0] w);
		rst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		chk_bit(debug_sync_oe_n, 1'b1);
		prog(2'h1, 1'b0, 1'b0);
		otp_prog_req = 1'b0;
		sw_req(1'b0);
		otp_load_word = w;
		otp_load_valid = 1'b1;
		@(negedge sys_clk);
		otp_load_valid = 1'b0;
		@(negedge sys_clk);
		chk_word(tile_security_config, w);
		chk_bit(sec_loaded, 1'b1);
		chk_bit(boot_from_otp, w[5]);
		chk_bit(otp_redundant_rows, w[7]);
	endtask
	// Far side pulls the pin, then a breakpoint lets the device pull it
	task automatic dbg(input logic off);
		debug_out_en = 1'b1;
		debug_in_en = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk_bit(debug_sync_oe_n, 1'b1);
		ext_low = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk_bit(debug_enter, ~off);
		ext_low = 1'b0;
		breakpoint_hit = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk_bit(debug_sync_oe_n, off);
		chk_bit(debug_sync_out, 1'b0);
		breakpoint_hit = 1'b0;
	endtask
	// Both instructions, then 33 data bits: chip word first, boundary bit last
	task automatic op(input logic [3:0] bnd, input logic [3:0] chip, input logic [31:0] d);
		tsd_jtag_host_i.scan(1'b1, 8, {56'h0, bnd, chip});
		tsd_jtag_host_i.scan(1'b0, 33, {31'h0, 1'b0, d});
	endtask
	initial
	begin
		rst_n = 1'b0;
		otp_load_valid = 1'b0;
		otp_load_word = 32'h0;
		tile0_security_word = 32'h9E7ABCDE;
		otp_prog_req = 1'b0;
		otp_prog_sector = 2'h0;
		otp_prog_sec_word = 1'b0;
		switch_req = 1'b0;
		breakpoint_hit = 1'b0;
		debug_out_en = 1'b0;
		debug_in_en = 1'b0;
		ext_low = 1'b0;
		@(negedge sys_clk);
		boot(W1);
		sw_req(1'b0);
		for (int s = 0; s < 4; s++)
			prog(s[1:0], 1'b0, ~W1[8 + s]);
		prog(2'h0, 1'b1, 1'b1);
		otp_prog_req = 1'b0;
		dbg(1'b0);
		tsd_jtag_host_i.scan(1'b0, 40, 64'h0);
		chk_word(tsd_jtag_host_i.rec[39:8], 32'h0);
		tsd_jtag_host_i.release_reset(100);
		tsd_jtag_host_i.to_idle();
		tsd_jtag_host_i.scan(1'b0, 33, 64'h0);
		chk_bit(found(tsd_jtag_host_i.rec, {tsd_pkg::ID_VERSION, tsd_pkg::ID_PART,
			tsd_pkg::ID_MAKER, 1'b1}), 1'b1);
		op(tsd_pkg::IR_SAMPLE, tsd_pkg::IR_USERCODE, D1);
		chk_bit(found(tsd_jtag_host_i.rec, {tile0_security_word[31:22], 12'h000,
			tsd_pkg::REVISION}), 1'b1);
		op(tsd_pkg::IR_EXTEST, tsd_pkg::IR_CHIP_DATA, D1);
		chk_bit(found(tsd_jtag_host_i.rec, W1), 1'b1);
		chk_word(tile_wrs, 32'h1);
		chk_word(wr_seen, D1);
		op(tsd_pkg::IR_BYPASS, tsd_pkg::IR_OTP_DATA, D2);
		chk_word(otp_wrs, 32'h1);
		chk_word(wr_seen, D2);
		boot(W2);
		sw_req(1'b1);
		for (int s = 0; s < 4; s++)
			prog(s[1:0], 1'b0, 1'b0);
		prog(2'h2, 1'b1, 1'b0);
		otp_prog_req = 1'b0;
		dbg(1'b1);
		op(tsd_pkg::IR_BYPASS, tsd_pkg::IR_OTP_DATA, D1);
		chk_word(otp_wrs, 32'h1);
		op(tsd_pkg::IR_BYPASS, tsd_pkg::IR_CHIP_DATA, D2);
		chk_word(tile_wrs, 32'h2);
		boot(W3);
		op(tsd_pkg::IR_BYPASS, tsd_pkg::IR_CHIP_DATA, D1);
		chk_bit(found(tsd_jtag_host_i.rec, W3), 1'b0);
		chk_word(tile_wrs, 32'h2);
		final_report();
	end
endmodule // tb
`default_nettype wire
